// >>> src/gpio_port_pkg.sv
/*
   Constants for the general-purpose port block: register offsets, field
   positions, reset values and filter timing.
   Assumes a 32-bit classic Wishbone slave; registers are word-aligned except direction at 12'h252.
*/
// Operation
// (RULE1) Readback returns buffered pin levels always
// (RULE2) Readback register read-only, writes change nothing
// (RULE3) Direction bit one output, zero input
// (RULE4) Bit 7 bus controller forces output
// (RULE5) Bit 6 peripheral forces input
// (RULE6) Bit 5 serial interface sets own direction
// (RULE7) Override keeps stored bit, restores later
// (RULE8) Per-pin interrupt enable and edge select
// (RULE9) All pins feed one interrupt request
// (RULE10) Edge detection works for output pins
// (RULE11) Request while flag and enable set; code also needs the mask bit set
// (RULE12) Qualified interrupt wakes from stop, wait
// (RULE13) Filter drops three clocks, accepts four
// (RULE14) Filtered edge sets flag, write one clears
// (RULE15) Direction and enables reset to zero
package gpio_port_pkg;
   localparam int PIN_COUNT = 8;
   localparam logic [11:0] OFS_DIRECTION = 12'h252;
   localparam logic [11:0] OFS_PIN_LEVEL = 12'h254;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h258;
   localparam logic [11:0] OFS_IRQ_POLARITY = 12'h25c;
   localparam logic [11:0] OFS_IRQ_FLAG = 12'h260;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h264;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [7:0] IRQ_POLARITY_RESET = 8'h00;
   localparam logic [7:0] IRQ_FLAG_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'hff;
   localparam int BIT_FORCE_OUT = 7;
   localparam int BIT_FORCE_IN = 6;
   localparam int BIT_SPI = 5;
   localparam int FILTER_ACCEPT_CLOCKS = 4;
   localparam int FILTER_COUNT_W = 3;
endpackage

// >>> src/pin_sync.sv
/*
   Two-flop synchroniser for one pin level.
   Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_sync
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// >>> src/pulse_filter.sv
/*
   Per-pin glitch filter: output follows input only after the input has
   held a new level for ACCEPT clocks.
   Assumes a synchronised input.
*/
`timescale 1ns/1ps
module pulse_filter
   import gpio_port_pkg::*;
#(
   parameter int ACCEPT = FILTER_ACCEPT_CLOCKS
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic level_in,
   output logic level_out
);
   logic [FILTER_COUNT_W-1:0] count_reg;
   wire differs = level_in != level_out;
   wire reached = count_reg == FILTER_COUNT_W'(ACCEPT - 1);

   // Three-clock pulses must still be dropped
   if (ACCEPT < 4 || ACCEPT > 8)
   begin : g_bad_accept
      $error("pulse_filter: ACCEPT out of range");
   end

   // Stable for ACCEPT clocks including the commit edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= '0;
         level_out <= 1'b0;
      end
      else if (!differs)
         count_reg <= '0;
      else if (reached)
      begin
         count_reg <= '0;
         level_out <= level_in;
      end
      else
         count_reg <= count_reg + FILTER_COUNT_W'(1);
   end

   property p_short_pulse_dropped;
      @(posedge clk) disable iff (!rst_b)
      !differs ##1 differs [*3] ##1 !differs |-> level_out == $past(level_out, 4);
   endproperty
   a_short_pulse_dropped: assert property (p_short_pulse_dropped) // RULE13
      else $error("Short pulse passed the filter");
endmodule

// >>> src/gpio_port.sv
/*
   Port block: direction register with peripheral override, pin level
   readback, and edge-triggered pin interrupts with glitch filter.
   Assumes a classic Wishbone master on clk and asynchronous pins.
*/
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module gpio_port
   import gpio_port_pkg::*;
#(
   parameter int WIDTH = PIN_COUNT
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out_data,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   input wire logic bus_controller_owns_pin7,
   input wire logic bus_controller_owns_pin6,
   input wire logic serial_peripheral_zero_en,
   input wire logic serial_peripheral_zero_pin5_out,
   input wire logic low_power_mode,
   output logic port_irq,
   output logic wake_request
);
   logic [7:0] pin_direction_bits_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] irq_polarity_reg;
   logic [7:0] irq_flag_reg;
   logic [7:0] irq_flag_next;
   logic [7:0] irq_mask_reg;
   logic [7:0] filtered_prev_reg;
   logic [WIDTH-1:0] pin_synced;
   logic [WIDTH-1:0] pin_filtered;
   logic [7:0] pin_level_readback;
   logic [31:0] rd_data;

   if (WIDTH != 8)
   begin : g_bad_width
      $error("gpio_port: WIDTH must be 8");
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : gen_pin
         pin_sync u_sync
         (
            .clk(clk),
            .rst_b(rst_b),
            .async_in(pin_in[g]),
            .sync_out(pin_synced[g])
         );
         pulse_filter #(.ACCEPT(FILTER_ACCEPT_CLOCKS)) u_filter // RULE13
         (
            .clk(clk),
            .rst_b(rst_b),
            .level_in(pin_synced[g]),
            .level_out(pin_filtered[g])
         );
      end
   endgenerate

   // Readback is the synchronised pin, independent of direction
   assign pin_level_readback = pin_synced; // RULE1

   // Bus decode
   wire access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire hit_dir = wb_adr_i == OFS_DIRECTION;
   wire hit_lvl = wb_adr_i == OFS_PIN_LEVEL;
   wire hit_ien = wb_adr_i == OFS_IRQ_ENABLE;
   wire hit_pol = wb_adr_i == OFS_IRQ_POLARITY;
   wire hit_flg = wb_adr_i == OFS_IRQ_FLAG;
   wire hit_msk = wb_adr_i == OFS_IRQ_MASK;
   wire mapped = hit_dir || hit_lvl || hit_ien || hit_pol || hit_flg || hit_msk;
   wire wr_lane0 = access && wb_we_i && wb_sel_i[0];
   wire wr_dir = wr_lane0 && hit_dir;
   wire wr_ien = wr_lane0 && hit_ien;
   wire wr_pol = wr_lane0 && hit_pol;
   wire wr_flg = wr_lane0 && hit_flg;
   wire wr_msk = wr_lane0 && hit_msk;
   wire [7:0] wr_byte = wb_dat_i[7:0];

   assign rd_data = hit_dir ? {24'h0, pin_direction_bits_reg} :
                    hit_lvl ? {24'h0, pin_level_readback} :
                    hit_ien ? {24'h0, irq_enable_reg} :
                    hit_pol ? {24'h0, irq_polarity_reg} :
                    hit_flg ? {24'h0, irq_flag_reg} :
                    hit_msk ? {24'h0, irq_mask_reg} : 32'h0;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= access && mapped;
         wb_err_o <= access && !mapped;
         wb_dat_o <= (access && !wb_we_i) ? rd_data : 32'h0;
      end
   end

   // Writes to the readback offset decode to no register at all
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_direction_bits_reg <= DIRECTION_RESET; // RULE15
         irq_enable_reg <= IRQ_ENABLE_RESET; // RULE15
         irq_polarity_reg <= IRQ_POLARITY_RESET;
         irq_mask_reg <= IRQ_MASK_RESET;
      end
      else
      begin
         if (wr_dir)
            pin_direction_bits_reg <= wr_byte; // RULE3
         if (wr_ien)
            irq_enable_reg <= wr_byte; // RULE8
         if (wr_pol)
            irq_polarity_reg <= wr_byte; // RULE8
         if (wr_msk)
            irq_mask_reg <= wr_byte;
      end
   end

   // Direction: overrides never touch the stored bits
   logic [7:0] oe_eff;
   always_comb
   begin
      oe_eff = pin_direction_bits_reg; // RULE3 RULE7
      if (bus_controller_owns_pin7)
         oe_eff[BIT_FORCE_OUT] = 1'b1; // RULE4
      if (bus_controller_owns_pin6)
         oe_eff[BIT_FORCE_IN] = 1'b0; // RULE5
      if (serial_peripheral_zero_en)
         oe_eff[BIT_SPI] = serial_peripheral_zero_pin5_out; // RULE6
   end
   assign pin_oe = oe_eff;
   assign pin_out = pin_out_data;

   // Edges seen on the filtered level, whatever the direction
   wire [7:0] rise = pin_filtered & ~filtered_prev_reg; // RULE10
   wire [7:0] fall = ~pin_filtered & filtered_prev_reg;
   wire [7:0] edge_hit = (irq_polarity_reg & rise) | (~irq_polarity_reg & fall);

   // Set wins over a write-one clear in the same cycle
   assign irq_flag_next = (irq_flag_reg & ~(wr_flg ? wr_byte : 8'h00)) | edge_hit; // RULE14

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         filtered_prev_reg <= 8'h00;
         irq_flag_reg <= IRQ_FLAG_RESET;
      end
      else
      begin
         filtered_prev_reg <= pin_filtered;
         irq_flag_reg <= irq_flag_next;
      end
   end

   wire [7:0] qualified = irq_flag_reg & irq_enable_reg; // RULE11
   assign port_irq = |(qualified & irq_mask_reg); // RULE9
   assign wake_request = low_power_mode && |qualified; // RULE12

   property p_irq_from_flag;
      @(posedge clk) disable iff (!rst_b)
      |(irq_flag_reg & irq_enable_reg & irq_mask_reg) |-> port_irq;
   endproperty
   a_irq_from_flag: assert property (p_irq_from_flag) // RULE11
      else $error("Interrupt missing while flag and enable set");

   property p_no_irq_without_flag;
      @(posedge clk) disable iff (!rst_b)
      (irq_flag_reg & irq_enable_reg) == 8'h00 |-> !port_irq;
   endproperty
   a_no_irq_without_flag: assert property (p_no_irq_without_flag) // RULE9
      else $error("Interrupt without qualified flag");

   property p_force_out;
      @(posedge clk) disable iff (!rst_b)
      bus_controller_owns_pin7 |-> pin_oe[BIT_FORCE_OUT];
   endproperty
   a_force_out: assert property (p_force_out) // RULE4
      else $error("Pin 7 not driven while owned");

   property p_force_in;
      @(posedge clk) disable iff (!rst_b)
      bus_controller_owns_pin6 |-> !pin_oe[BIT_FORCE_IN];
   endproperty
   a_force_in: assert property (p_force_in) // RULE5
      else $error("Pin 6 driven while owned");

   property p_spi_dir;
      @(posedge clk) disable iff (!rst_b)
      serial_peripheral_zero_en |-> pin_oe[BIT_SPI] == serial_peripheral_zero_pin5_out;
   endproperty
   a_spi_dir: assert property (p_spi_dir) // RULE6
      else $error("Pin 5 direction not from serial interface");

   property p_dir_plain;
      @(posedge clk) disable iff (!rst_b)
      pin_oe[4:0] == pin_direction_bits_reg[4:0];
   endproperty
   a_dir_plain: assert property (p_dir_plain) // RULE3
      else $error("Direction bits not applied");

   property p_override_keeps_bits;
      @(posedge clk) disable iff (!rst_b)
      !wr_dir |=> $stable(pin_direction_bits_reg);
   endproperty
   a_override_keeps_bits: assert property (p_override_keeps_bits) // RULE7
      else $error("Direction bits changed without a write");

   property p_edge_sets_flag;
      @(posedge clk) disable iff (!rst_b)
      |edge_hit |=> (irq_flag_reg & $past(edge_hit)) == $past(edge_hit);
   endproperty
   a_edge_sets_flag: assert property (p_edge_sets_flag) // RULE14
      else $error("Selected edge did not set its flag");

   property p_readback;
      @(posedge clk) disable iff (!rst_b)
      access && !wb_we_i && hit_lvl |=> wb_dat_o[7:0] == $past(pin_synced);
   endproperty
   a_readback: assert property (p_readback) // RULE1
      else $error("Readback differs from pin levels");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      low_power_mode && |(irq_flag_reg & irq_enable_reg) |-> wake_request;
   endproperty
   a_wake: assert property (p_wake) // RULE12
      else $error("No wake on qualified interrupt");

   property p_ack_one_cycle;
      @(posedge clk) disable iff (!rst_b)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle)
      else $error("Acknowledge held for two cycles");

   property p_err_one_cycle;
      @(posedge clk) disable iff (!rst_b)
      wb_err_o |=> !wb_err_o;
   endproperty
   a_err_one_cycle: assert property (p_err_one_cycle)
      else $error("Error held for two cycles");

   property p_ack_follows_access;
      @(posedge clk) disable iff (!rst_b)
      access && mapped |=> wb_ack_o && !wb_err_o;
   endproperty
   a_ack_follows_access: assert property (p_ack_follows_access)
      else $error("Mapped access not acknowledged");

   property p_err_unmapped;
      @(posedge clk) disable iff (!rst_b)
      access && !mapped |=> wb_err_o && !wb_ack_o;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("Unmapped access not refused");

   property p_level_write_ignored;
      @(posedge clk) disable iff (!rst_b)
      access && wb_we_i && hit_lvl |=> $stable(pin_direction_bits_reg) &&
         $stable(irq_enable_reg) && $stable(irq_polarity_reg) && $stable(irq_mask_reg);
   endproperty
   a_level_write_ignored: assert property (p_level_write_ignored) // RULE2
      else $error("Write to readback changed a register");

   property p_level_write_acked;
      @(posedge clk) disable iff (!rst_b)
      access && wb_we_i && hit_lvl |=> wb_ack_o;
   endproperty
   a_level_write_acked: assert property (p_level_write_acked) // RULE2
      else $error("Write to readback not acknowledged");

   property p_dir_write;
      @(posedge clk) disable iff (!rst_b)
      wr_dir |=> pin_direction_bits_reg == $past(wr_byte);
   endproperty
   a_dir_write: assert property (p_dir_write) // RULE3
      else $error("Direction write lost");

   property p_override_released;
      @(posedge clk) disable iff (!rst_b)
      !bus_controller_owns_pin7 && !bus_controller_owns_pin6 && !serial_peripheral_zero_en
         |-> pin_oe == pin_direction_bits_reg;
   endproperty
   a_override_released: assert property (p_override_released) // RULE7
      else $error("Direction bits not in control after override");

   property p_enable_write;
      @(posedge clk) disable iff (!rst_b)
      wr_ien |=> irq_enable_reg == $past(wr_byte);
   endproperty
   a_enable_write: assert property (p_enable_write) // RULE8
      else $error("Interrupt enable write lost");

   property p_polarity_write;
      @(posedge clk) disable iff (!rst_b)
      wr_pol |=> irq_polarity_reg == $past(wr_byte);
   endproperty
   a_polarity_write: assert property (p_polarity_write) // RULE8
      else $error("Edge select write lost");

   property p_flag_clear;
      @(posedge clk) disable iff (!rst_b)
      wr_flg && !(|edge_hit) |=> (irq_flag_reg & $past(wr_byte)) == 8'h00;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // RULE14
      else $error("Write of one did not clear the flag");

   property p_flag_holds;
      @(posedge clk) disable iff (!rst_b)
      !wr_flg && !(|edge_hit) |=> $stable(irq_flag_reg);
   endproperty
   a_flag_holds: assert property (p_flag_holds) // RULE14
      else $error("Flag changed without edge or clear");

   property p_output_edge;
      @(posedge clk) disable iff (!rst_b)
      |(rise & irq_polarity_reg & pin_oe) |=>
         |(irq_flag_reg & $past(rise & irq_polarity_reg & pin_oe));
   endproperty
   a_output_edge: assert property (p_output_edge) // RULE10
      else $error("Edge on an output pin not flagged");

   property p_wake_quiet;
      @(posedge clk) disable iff (!rst_b)
      !low_power_mode |-> !wake_request;
   endproperty
   a_wake_quiet: assert property (p_wake_quiet) // RULE12
      else $error("Wake request outside low power mode");
endmodule

// >>> testbench/pin_model.sv
/*
   Board side of the port: resolves each pin from the block's drive and
   an external level.
   Assumes no contention matters: a driven pin shows the block's value.
*/
`timescale 1ns/1ps
module pin_model
(
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_in
);
   // Driven pins read back their own value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> testbench/tb_port_pin_direction_and_pin_interrupt.sv
/*
   Self-checking bench for the port block: registers, overrides, filter
   and pin interrupts.
   Assumes pin_model stands for the board; the bench drives the peripheral signals itself.
*/
`timescale 1ns/1ps
module tb_port_pin_direction_and_pin_interrupt;
   import gpio_port_pkg::*;
   logic clk = 0;
   logic rst_b = 0;
   logic cyc = 0, stb = 0, we = 0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, err, irq, wake, got_err;
   logic [7:0] pin_in, pin_out, pin_oe, q;
   logic [7:0] ext = 8'h00, odat = 8'h00;
   logic own7 = 0, own6 = 0, spi_en = 0, spi_out = 0, lpm = 0;
   int n_fail = 0;
   int cmp_count = 0;

   gpio_port dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_in(pin_in),
      .pin_out_data(odat), .pin_out(pin_out), .pin_oe(pin_oe),
      .bus_controller_owns_pin7(own7), .bus_controller_owns_pin6(own6),
      .serial_peripheral_zero_en(spi_en),
      .serial_peripheral_zero_pin5_out(spi_out), .low_power_mode(lpm),
      .port_irq(irq), .wake_request(wake));

   pin_model board_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_in(pin_in));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      if (n >= 50)
         n_fail++;
      q = rdat[7:0];
      got_err = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input logic [7:0] p, input int n);
      ext <= p;
      idle(n);
      ext <= 8'h00;
      idle(12);
   endtask

   task automatic t_reset;
      rd(OFS_DIRECTION, 8'h00);
      rd(OFS_IRQ_ENABLE, 8'h00);
      rd(OFS_IRQ_POLARITY, IRQ_POLARITY_RESET);
      rd(OFS_IRQ_FLAG, IRQ_FLAG_RESET);
      rd(OFS_IRQ_MASK, IRQ_MASK_RESET);
      chk(pin_oe, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_dir;
      wb(1'b1, OFS_DIRECTION, 8'h65);
      rd(OFS_DIRECTION, 8'h65);
      chk(pin_oe, 8'h65);
      own7 <= 1'b1;
      own6 <= 1'b1;
      spi_en <= 1'b1;
      idle(1);
      chk(pin_oe, 8'h85);
      spi_out <= 1'b1;
      idle(1);
      chk(pin_oe, 8'ha5);
      rd(OFS_DIRECTION, 8'h65);
      own7 <= 1'b0;
      own6 <= 1'b0;
      spi_en <= 1'b0;
      idle(1);
      chk(pin_oe, 8'h65);
      $display("test direction done");
   endtask

   task automatic t_level;
      wb(1'b1, OFS_DIRECTION, 8'h0f);
      odat <= 8'h0a;
      ext <= 8'hc0;
      idle(4);
      rd(OFS_PIN_LEVEL, 8'hca);
      chk(pin_out, 8'h0a);
      wb(1'b1, OFS_PIN_LEVEL, 8'h33);
      rd(OFS_PIN_LEVEL, 8'hca);
      rd(OFS_DIRECTION, 8'h0f);
      wb(1'b1, 12'h300, 8'hff);
      chk({7'h0, got_err}, 8'h01);
      rd(OFS_DIRECTION, 8'h0f);
      $display("test level done");
   endtask

   task automatic t_irq;
      wb(1'b1, OFS_DIRECTION, 8'h04);
      odat <= 8'h00;
      ext <= 8'h00;
      wb(1'b1, OFS_IRQ_POLARITY, 8'h07);
      wb(1'b1, OFS_IRQ_ENABLE, 8'h05);
      idle(12);
      wb(1'b1, OFS_IRQ_FLAG, 8'hff);
      pulse(8'h01, 3);
      rd(OFS_IRQ_FLAG, 8'h00);
      chk({7'h0, irq}, 8'h00);
      pulse(8'h01, 4);
      rd(OFS_IRQ_FLAG, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wb(1'b1, OFS_IRQ_MASK, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, OFS_IRQ_MASK, 8'hff);
      lpm <= 1'b1;
      idle(1);
      chk({7'h0, wake}, 8'h01);
      wb(1'b1, OFS_IRQ_FLAG, 8'h01);
      rd(OFS_IRQ_FLAG, 8'h00);
      chk({6'h0, wake, irq}, 8'h00);
      ext <= 8'h02;
      idle(12);
      rd(OFS_IRQ_FLAG, 8'h02);
      chk({7'h0, irq}, 8'h00);
      odat <= 8'h04;
      idle(12);
      rd(OFS_IRQ_FLAG, 8'h06);
      chk({7'h0, irq}, 8'h01);
      $display("test interrupt done");
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      idle(20);
      rst_b <= 1'b1;
      t_reset();
      t_dir();
      t_level();
      t_irq();
      tally_and_finish();
   end

   initial
   begin
      idle(20000);
      n_fail++;
      tally_and_finish();
   end
endmodule
